// ### src/pwpb_bridge.sv
// ahb to apb bridge with per peripheral write guarding
`default_nettype none
// Functional notes
// R01 - A one written to the clear view clears that protection bit and unguards the peripheral.
// R02 - A one written to the set view sets that protection bit and guards the peripheral.
// R03 - Both views read back the same current protection bits.
// R04 - A write to a guarded peripheral is dropped and answered with an access error.
// R05 - Writing a one to the set view for an already guarded peripheral answers an error.
// R06 - Writing a one to the clear view for an already unguarded peripheral answers an error.
// R07 - A zero written to either view leaves its protection bit unchanged.
// R08 - The bridge is an ahb slave that forwards to apb4 with waits, errors and protection.
// R09 - Address and data go out on apb together in one combined cycle.
// R10 - Byte, half-word and word transfers carry byte strobes for reads and writes alike.
// R11 - The bridge ahb clock must be running before any transfer is tried.
// R12 - Software sharing a peripheral should read the set view before unprotecting it.
// R13 - Guard errors come back as apb error and then as a two cycle ahb error. Blocked writes skip the apb error and go straight to the ahb error.
module pwpb_bridge
  import pwpb_pkg::*;
#(
  parameter int NUM_PERIPH = PWPB_NUM_PERIPH
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // ahb slave side
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [3:0] hprot,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [1:0] hresp,
  output logic [31:0] hrdata,
  // apb master side to peripherals
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  output logic [2:0] pprot,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  import pwpb_pkg::*;

  typedef enum logic [2:0] {IDLE, LOAD, ACCESS, ERR1, ERR2} pwpb_phase_type;
  typedef struct packed {
    pwpb_phase_type phase;
    logic wr;
    logic unit;
    logic [31:0] addr;
    logic [3:0] strb;
    logic [2:0] prot;
    logic [31:0] wdata;
    logic [31:0] rdata;
  } pwpb_state_type;
  pwpb_state_type st_q;
  pwpb_state_type st_d;
  pwpb_apb_if gu_bus ();
  logic take;
  logic [3:0] slot;
  logic blocked;
  logic done;
  logic err;
  logic [31:0] rd;

  // strobe lanes from size and low address, used for reads too
  function automatic logic [3:0] lanes(input logic [2:0] sz, input logic [1:0] a);
    logic [3:0] m;
    m = 4'h0;
    case (sz)
      3'h0: m = 4'h1 << a;
      3'h1: m = a[1] ? 4'hC : 4'h3;
      default: m = 4'hF;
    endcase
    return m;
  endfunction

  pwpb_guard_unit u_guard (
    .clk(clk),
    .srst(srst),
    .apb(gu_bus.unit)
  );

  // ----------------------------------------------------------------
  // apb routing: slot 15 is the guard unit, others are peripherals
  // ----------------------------------------------------------------
  assign slot = st_q.addr[15:12];
  assign gu_bus.psel = st_q.phase == ACCESS && st_q.unit;
  assign gu_bus.penable = gu_bus.psel;
  assign gu_bus.pwrite = st_q.wr;
  assign gu_bus.paddr = st_q.addr;
  assign gu_bus.pwdata = st_q.wdata;
  assign gu_bus.pstrb = st_q.strb;
  assign gu_bus.pprot = st_q.prot;

  // combined address and data cycle: psel and penable rise together
  assign psel = st_q.phase == ACCESS && !st_q.unit; // R09
  assign penable = psel; // R09
  assign pwrite = st_q.wr;
  assign paddr = st_q.addr;
  assign pwdata = st_q.wdata;
  // read strobes are kept: sizing applies to reads too, unlike plain apb4
  assign pstrb = st_q.strb; // R10
  assign pprot = st_q.prot; // R08
  assign done = st_q.unit ? gu_bus.pready : pready;
  assign err = st_q.unit ? gu_bus.pslverr : pslverr; // R13
  assign rd = st_q.unit ? gu_bus.prdata : prdata;

  // ----------------------------------------------------------------
  // ahb address phase capture and transfer sequencing
  // ----------------------------------------------------------------
  // a transfer is taken only while the bus shows ready
  assign take = hsel && hready && htrans[1];
  // guard check on the captured write; the guard unit itself is never blocked
  assign blocked = st_q.wr && !st_q.unit && slot < 4'(NUM_PERIPH) &&
                   gu_bus.guard[slot[2:0]];

  always_comb begin
    st_d = st_q;
    case (st_q.phase)
      // a new transfer may start in the last error cycle, when hreadyout is high
      IDLE, ERR2: begin
        st_d.phase = IDLE;
        if (take) begin
          st_d.phase = LOAD;
          st_d.wr = hwrite;
          st_d.addr = haddr;
          st_d.unit = haddr[15:12] == PWPB_GUARD_SLOT;
          st_d.strb = lanes(hsize, haddr[1:0]); // R10
          st_d.prot = {~hprot[0], 1'b0, hprot[1]}; // R08
        end
      end
      // data phase: latch hwdata so apb gets address and data in one cycle
      LOAD: begin
        st_d.wdata = hwdata; // R09
        st_d.phase = blocked ? ERR1 : ACCESS; // R04
      end
      ACCESS: begin
        if (blocked) begin
          st_d.phase = ERR1; // R04
        end else if (done) begin
          st_d.rdata = rd;
          st_d.phase = err ? ERR1 : IDLE; // R08 R13
        end
      end
      ERR1: st_d.phase = ERR2;
      default: st_d.phase = IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= '{phase: IDLE, default: '0};
    end else begin
      st_q <= st_d;
    end
  end

  // ahb answer: wait while busy, two cycle error response
  assign hreadyout = st_q.phase == IDLE || st_q.phase == ERR2; // R08
  assign hresp = (st_q.phase == ERR1 || st_q.phase == ERR2) ? PWPB_HRESP_ERROR
                                                             : PWPB_HRESP_OKAY;
  assign hrdata = st_q.rdata;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // guarded writes never reach a peripheral select
  blocked_no_psel_a: assert property (@(posedge clk) disable iff (srst) // R04
    blocked |-> !psel) else $error("blocked write reached peripheral");
  blocked_err_a: assert property (@(posedge clk) disable iff (srst) // R04
    (st_q.phase == LOAD && blocked) |=> hresp == PWPB_HRESP_ERROR && !hreadyout)
    else $error("blocked write not errored");
  err_two_a: assert property (@(posedge clk) disable iff (srst) // R13
    (st_q.phase == ERR1) |=> hreadyout && hresp == PWPB_HRESP_ERROR)
    else $error("error response not two cycles");
  merged_cycle_a: assert property (@(posedge clk) disable iff (srst) // R09
    psel |-> penable && (!pwrite || pwdata == hwdata)) else $error("separate setup phase seen");
  strobe_word_a: assert property (@(posedge clk) disable iff (srst) // R10
    (take && hsize == 3'h2) |=> st_q.strb == 4'hF) else $error("word strobe wrong");
  set_bit_a: assert property (@(posedge clk) disable iff (srst) // R02
    (gu_bus.psel && st_q.wr && st_q.addr[7:0] == PWPB_SET_VIEW_OFS && st_q.strb[0])
    |=> (gu_bus.guard & $past(st_q.wdata[7:0])) == $past(st_q.wdata[7:0]))
    else $error("set view did not set");
  clr_bit_a: assert property (@(posedge clk) disable iff (srst) // R01
    (gu_bus.psel && st_q.wr && st_q.addr[7:0] == PWPB_CLEAR_VIEW_OFS && st_q.strb[0])
    |=> (gu_bus.guard & $past(st_q.wdata[7:0])) == 8'h00)
    else $error("clear view did not clear");
  views_same_a: assert property (@(posedge clk) disable iff (srst) // R03
    gu_bus.prdata[7:0] == gu_bus.guard) else $error("views differ");
  dup_set_a: assert property (@(posedge clk) disable iff (srst) // R05
    (gu_bus.psel && st_q.wr && st_q.addr[7:0] == PWPB_SET_VIEW_OFS && st_q.strb[0]
     && |(st_q.wdata[7:0] & gu_bus.guard)) |=> hresp == PWPB_HRESP_ERROR)
    else $error("double protect not errored");
  dup_clr_a: assert property (@(posedge clk) disable iff (srst) // R06
    (gu_bus.psel && st_q.wr && st_q.addr[7:0] == PWPB_CLEAR_VIEW_OFS && st_q.strb[0]
     && |(st_q.wdata[7:0] & ~gu_bus.guard)) |=> hresp == PWPB_HRESP_ERROR)
    else $error("double unprotect not errored");

  // strobe lanes and protection bits follow the captured address phase
  read_strobe_a: assert property (@(posedge clk) disable iff (srst) // R10
    (psel && !pwrite) |-> pstrb != 4'h0) else $error("read strobes missing");
  byte_lane_a: assert property (@(posedge clk) disable iff (srst) // R10
    (take && hreadyout && hsize == 3'h0) |=> $onehot(st_q.strb)) else $error("byte lane wrong");
  half_lane_a: assert property (@(posedge clk) disable iff (srst) // R10
    (take && hreadyout && hsize == 3'h1) |=> st_q.strb == 4'h3 || st_q.strb == 4'hC)
    else $error("half lane wrong");
  prot_map_a: assert property (@(posedge clk) disable iff (srst) // R08
    (take && hreadyout) |=> pprot[0] == $past(hprot[1]) && pprot[2] == !$past(hprot[0]))
    else $error("protection bits wrong");
  // the data phase always waits one cycle before the combined apb cycle, or before the error response for a blocked write
  load_wait_a: assert property (@(posedge clk) disable iff (srst) // R08
    (st_q.phase == LOAD) |-> !hreadyout && !psel) else $error("load cycle not waited");
  slave_err_a: assert property (@(posedge clk) disable iff (srst) // R13
    (st_q.phase == ACCESS && !st_q.unit && pready && pslverr)
    |=> hresp == PWPB_HRESP_ERROR && !hreadyout) else $error("slave error not passed on");
endmodule
`default_nettype wire

// ### src/pwpb_pkg.sv
// package of constants for the peripheral write protect bridge
`default_nettype none
package pwpb_pkg;
  // ----------------------------------------------------------------
  // guard register map, sizing and ahb codes
  // ----------------------------------------------------------------
  localparam int PWPB_NUM_PERIPH = 8;
  localparam int PWPB_PERIPH_AW = 8;
  localparam logic [7:0] PWPB_CLEAR_VIEW_OFS = 8'h00;
  localparam logic [7:0] PWPB_SET_VIEW_OFS = 8'h04;
  localparam logic [7:0] PWPB_GUARD_RESET = 8'h00;
  localparam logic [3:0] PWPB_GUARD_SLOT = 4'hF;
  localparam logic [1:0] PWPB_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] PWPB_HRESP_OKAY = 2'h0;
  localparam logic [1:0] PWPB_HRESP_ERROR = 2'h1;
endpackage
`default_nettype wire

// ### src/pwpb_apb_if.sv
// apb side bundle between the bridge and the peripheral guard unit
`default_nettype none
interface pwpb_apb_if;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] paddr;
  logic [31:0] pwdata;
  logic [3:0] pstrb;
  logic [2:0] pprot;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] guard;
  modport bridge (output psel, penable, pwrite, paddr, pwdata, pstrb, pprot,
                  input prdata, pready, pslverr, guard);
  modport unit (input psel, penable, pwrite, paddr, pwdata, pstrb, pprot,
                output prdata, pready, pslverr, guard);
endinterface
`default_nettype wire

// ### src/pwpb_guard_unit.sv
// peripheral guard unit: protection bits behind the clear and set views
`default_nettype none
module pwpb_guard_unit
  import pwpb_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // register access
  pwpb_apb_if.unit apb
);
  typedef struct packed {
    logic [7:0] guard;
  } pwpb_gu_state_type;
  pwpb_gu_state_type st_q;
  pwpb_gu_state_type st_d;
  logic is_wr;
  logic hit_clr;
  logic hit_set;
  logic [7:0] wbits;

  // ----------------------------------------------------------------
  // decode and update
  // ----------------------------------------------------------------
  assign is_wr = apb.psel && apb.penable && apb.pwrite;
  assign hit_clr = apb.paddr[7:0] == PWPB_CLEAR_VIEW_OFS;
  assign hit_set = apb.paddr[7:0] == PWPB_SET_VIEW_OFS;
  assign wbits = apb.pstrb[0] ? apb.pwdata[7:0] : 8'h00;

  // zeros leave bits alone; ones clear or set
  always_comb begin
    st_d = st_q;
    if (is_wr && hit_clr) begin
      st_d.guard = st_q.guard & ~wbits; // R01 R07
    end else if (is_wr && hit_set) begin
      st_d.guard = st_q.guard | wbits; // R02 R07
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= '{guard: PWPB_GUARD_RESET};
    end else begin
      st_q <= st_d;
    end
  end

  // both views read the same bits; repeated protect or unprotect flags error
  assign apb.prdata = {24'h000000, st_q.guard}; // R03
  assign apb.pready = 1'b1;
  assign apb.pslverr = is_wr && ((hit_set && |(wbits & st_q.guard)) || // R05
                                 (hit_clr && |(wbits & ~st_q.guard))); // R06
  assign apb.guard = st_q.guard;
endmodule
`default_nettype wire

// ### test/pwpb_periph_model.sv
// apb peripheral stand-in that answers the bridge after a set wait
`default_nettype none
module pwpb_periph_model (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // apb from the bridge
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // control and observation
  input wire logic [3:0] wait_n,
  output logic [31:0] last_data,
  output logic [3:0] last_strb,
  output logic [7:0] wr_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_q;
  logic [31:0] junk_q;
  // ready only after wait_n cycles of the access
  assign pready = psel && penable && cnt_q >= wait_n;
  // offsets 0xE00 to 0xEFF of any slot answer with a slave error
  assign pslverr = pready && paddr[11:8] == 4'hE;
  // unselected bus shows a toggling pattern, never stale data
  assign prdata = psel ? ~paddr : junk_q;
  // wait counter and record of accepted writes
  always_ff @(posedge clk) begin
    if (srst) begin
      junk_q <= 32'h5A5A_5A5A;
      cnt_q <= 4'h0;
      wr_cnt <= 8'h00;
      last_data <= 32'h0000_0000;
      last_strb <= 4'h0;
    end else begin
      junk_q <= ~junk_q;
      cnt_q <= (psel && penable && !pready) ? cnt_q + 4'h1 : 4'h0;
      // strobes are recorded for reads as well as writes
      if (pready) begin
        last_strb <= pstrb;
      end
      if (pready && pwrite) begin
        wr_cnt <= wr_cnt + 8'h01;
        last_data <= pwdata;
      end
    end
  end
endmodule
`default_nettype wire

// ### test/tb_top.sv
// self-checking bench for the peripheral write protect bridge
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module tb_top import pwpb_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, srst, hsel, hwrite, hreadyout, psel, penable, pwrite, pready, pslverr;
  logic [1:0] htrans, hresp, r;
  logic [2:0] hsize, pprot;
  logic [3:0] hprot, pstrb, wait_n, ls;
  logic [31:0] haddr, hwdata, hrdata, paddr, pwdata, prdata, q, lw;
  logic [7:0] wc, wc0;
  int num_errors = 0;
  int cmp_count = 0;
  localparam logic [31:0] clr_a = 32'h4000_F000;
  localparam logic [31:0] set_a = 32'h4000_F004;
  // single slave, so the bus ready loops back from our own
  pwpb_bridge uut (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hprot(hprot), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pprot(pprot),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  pwpb_periph_model per (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .wait_n(wait_n), .last_data(lw), .last_strb(ls),
    .wr_cnt(wc));
  // clock runs from time zero, before any transfer
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  function automatic logic [31:0] pa(input logic [3:0] n);
    return {16'h4000, n, 12'h010};
  endfunction
  // one ahb transfer; hwdata is left standing afterwards
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [2:0] sz,
      input logic [31:0] d, output logic [1:0] rs, output logic [31:0] rd);
    int n;
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= PWPB_HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= wr;
    hsize <= sz;
    @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    rs = hresp;
    rd = hrdata;
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ----------------
  // scenarios
  // ----------------
  task automatic t_reset();
    ahb(1'b0, clr_a, 3'h2, 32'h0, r, q);
    `CHK("clear view reset", PWPB_GUARD_RESET, q[7:0])
    ahb(1'b0, set_a, 3'h2, 32'h0, r, q);
    `CHK("set view reset", PWPB_GUARD_RESET, q[7:0])
  endtask
  task automatic t_plain();
    wait_n <= 4'h1;
    ahb(1'b1, pa(4'h2), 3'h2, 32'hCAFE_0123, r, q);
    `CHK("word resp", PWPB_HRESP_OKAY, r)
    `CHK("word data", 32'hCAFE_0123, lw)
    `CHK("word strb", 4'hF, ls)
    ahb(1'b1, pa(4'h2) + 32'h2, 3'h0, 32'h00AB_0000, r, q);
    `CHK("byte strb", 4'h4, ls)
    ahb(1'b1, pa(4'h2) + 32'h2, 3'h1, 32'h1234_0000, r, q);
    `CHK("half strb", 4'hC, ls)
    wait_n <= 4'h3;
    ahb(1'b0, pa(4'h5), 3'h2, 32'h0, r, q);
    `CHK("slow read", ~pa(4'h5), q)
    `CHK("read prot", 3'h1, pprot)
    ahb(1'b0, pa(4'h5) + 32'h1, 3'h0, 32'h0, r, q);
    `CHK("byte read strb", 4'h2, ls)
    ahb(1'b0, pa(4'h3) + 32'hE00, 3'h2, 32'h0, r, q);
    `CHK("slave err", PWPB_HRESP_ERROR, r)
  endtask
  task automatic t_guard();
    ahb(1'b1, set_a, 3'h2, 32'h0000_0004, r, q);
    `CHK("set resp", PWPB_HRESP_OKAY, r)
    ahb(1'b0, clr_a, 3'h2, 32'h0, r, q);
    `CHK("clear view", 8'h04, q[7:0])
    wc0 = wc;
    ahb(1'b1, pa(4'h2), 3'h2, 32'h1111_2222, r, q);
    `CHK("blocked resp", PWPB_HRESP_ERROR, r)
    `CHK("blocked count", wc0, wc)
    ahb(1'b1, set_a, 3'h2, 32'h0000_0004, r, q);
    `CHK("double set", PWPB_HRESP_ERROR, r)
    ahb(1'b1, clr_a, 3'h2, 32'h0, r, q);
    ahb(1'b0, set_a, 3'h2, 32'h0, r, q);
    `CHK("zero write", 8'h04, q[7:0])
    ahb(1'b1, clr_a, 3'h2, 32'h0000_0004, r, q);
    `CHK("clear resp", PWPB_HRESP_OKAY, r)
    ahb(1'b1, clr_a, 3'h2, 32'h0000_0004, r, q);
    `CHK("double clear", PWPB_HRESP_ERROR, r)
    ahb(1'b1, pa(4'h2), 3'h2, 32'h3333_4444, r, q);
    `CHK("unguarded data", 32'h3333_4444, lw)
  endtask
  // a reset in mid-run drops every protection bit
  task automatic t_rerun();
    ahb(1'b1, set_a, 3'h0, 32'h0000_0081, r, q);
    `CHK("byte set", PWPB_HRESP_OKAY, r)
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    ahb(1'b0, set_a, 3'h2, 32'h0, r, q);
    `CHK("rerun reset", PWPB_GUARD_RESET, q[7:0])
  endtask
  // main sequence
  initial begin
    {srst, hsel, haddr, htrans, hwrite, hsize, hwdata} = {1'b1, 71'h0};
    hprot = 4'h3;
    wait_n = 4'h1;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_plain();
    t_guard();
    t_rerun();
    close_out();
  end
  // watchdog: about a hundred cycles are expected
  initial begin
    repeat (3000) @(posedge clk);
    num_errors++;
    close_out();
  end
endmodule
`default_nettype wire
